// >>> hdl/tal_params.svh
// constants of the temperature alarm output block
`ifndef TAL_PARAMS_SVH
`define TAL_PARAMS_SVH
`define TAL_CLK_HZ        50000000
`define TAL_BLINK_MS      500
`define TAL_ADDR_W        8
`define TAL_OFS_CTRL      8'h00
`define TAL_OFS_MODES     8'h04
`define TAL_OFS_ABS_HI    8'h08
`define TAL_OFS_ABS_LO    8'h0c
`define TAL_OFS_DEV_HI    8'h10
`define TAL_OFS_DEV_LO    8'h14
`define TAL_OFS_STATUS    8'h18
`define TAL_OFS_ACK       8'h1c
`define TAL_CTRL_DIRECT   0
`define TAL_CTRL_NOPEN    1
`define TAL_RST_CTRL      2'h0
`define TAL_RST_MODES     6'h00
`define TAL_RST_LIMIT     16'h0000
`define TAL_MODE_HI_LSB   0
`define TAL_MODE_LO_LSB   2
`define TAL_MODE_DEV_LSB  4
`define TAL_ST_ANY        3
`define TAL_ST_MSG_LSB    4
`define TAL_ACK_BIT       0
`define TAL_RESP_OKAY     2'h0
`define TAL_RESP_SLVERR   2'h2
`endif

// >>> hdl/tal_pkg.sv
// types of the temperature alarm output block
`default_nettype none
package tal_pkg;
  typedef enum logic [1:0] {
    TAL_ALM_OFF,
    TAL_ALM_HELD,
    TAL_ALM_SELF_CLEAR
  } tal_alm_mode_t;
  typedef enum logic [1:0] {
    TAL_MSG_STD,
    TAL_MSG_ABS_HI,
    TAL_MSG_ABS_LO,
    TAL_MSG_DEV
  } tal_msg_t;
  typedef struct packed {
    logic          direct_sense;
    logic          relay_polarity_select;
    tal_alm_mode_t abs_high_alarm_mode;
    tal_alm_mode_t abs_low_alarm_mode;
    tal_alm_mode_t deviation_alarm_mode;
  } tal_cfg_t;
  typedef struct packed {
    logic signed [15:0] abs_high_limit;
    logic signed [15:0] abs_low_limit;
    logic signed [15:0] deviation_high_limit;
    logic signed [15:0] deviation_low_limit;
  } tal_limits_t;
endpackage
`default_nettype wire

// >>> hdl/tal_alarm_chan.sv
// one alarm channel with held, self-clearing or disabled behaviour
`default_nettype none
module tal_alarm_chan (
  input  wire logic               clk_sys_i,
  input  wire logic               reset_i,
  input  wire tal_pkg::tal_alm_mode_t mode_i,
  input  wire logic               cond_i,
  input  wire logic               ack_i,
  output logic                    active_o
);
  logic active_q;
  logic active_d;
  logic held_keep;

  // a press only clears when the condition is already gone
  assign held_keep = active_q & ~(ack_i & ~cond_i);

  always_comb begin
    case (mode_i)
      tal_pkg::TAL_ALM_HELD:       active_d = cond_i | held_keep;
      tal_pkg::TAL_ALM_SELF_CLEAR: active_d = cond_i;
      default:                     active_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_d;
    end
  end

  assign active_o = active_q;
endmodule
`default_nettype wire

// >>> hdl/tal_top.sv
// alarm evaluation and relay drive for output 3, control sense for outputs 1 and 2
//
// Behaviour
// - direct sense: control output level rises as measured input rises (cooling)
// - reverse sense: control output level falls as measured input rises (heating)
// - one sense setting drives both control outputs alike
// - absolute alarms compare probe 1, and probe 2 while enabled, with fixed high and low limits only
// - deviation alarm when probe strays beyond setpoint by high or low deviation
// - high and low deviation limits held separately, no ordering between them
// - any active alarm drives output 3 and a message naming it
// - each active alarm message alternates with standard display, one per alarm
// - held alarm stays active after its condition goes, until acknowledged
// - acknowledge does not clear a held alarm whose condition persists
// - self-clearing alarm drops as soon as the condition disappears
// - each alarm type has its own held, self-clearing or off mode
// - a disabled alarm type never asserts
// - polarity setting picks normally open or normally closed relay
// - normally open: working contact energised only while an alarm is active
// - normally closed: working contact energised while no alarm is present
// - with no alarm active, output 3 led lit while working contact is energised, else dark
// - output 3 led blinks while an alarm is active
// - after reset the relay polarity is normally closed
`include "tal_params.svh"
`default_nettype none
module tal_top #(
  parameter int unsigned BLINK_CYC = `TAL_BLINK_MS * (`TAL_CLK_HZ / 1000),
  parameter int unsigned LEVEL_W   = 16
) (
  input  wire logic                      clk_sys_i,
  input  wire logic                      reset_i,
  // axi4-lite slave
  input  wire logic [`TAL_ADDR_W-1:0]    s_axi_awaddr_i,
  input  wire logic                      s_axi_awvalid_i,
  output logic                           s_axi_awready_o,
  input  wire logic [31:0]               s_axi_wdata_i,
  input  wire logic [3:0]                s_axi_wstrb_i,
  input  wire logic                      s_axi_wvalid_i,
  output logic                           s_axi_wready_o,
  output logic [1:0]                     s_axi_bresp_o,
  output logic                           s_axi_bvalid_o,
  input  wire logic                      s_axi_bready_i,
  input  wire logic [`TAL_ADDR_W-1:0]    s_axi_araddr_i,
  input  wire logic                      s_axi_arvalid_i,
  output logic                           s_axi_arready_o,
  output logic [31:0]                    s_axi_rdata_o,
  output logic [1:0]                     s_axi_rresp_o,
  output logic                           s_axi_rvalid_o,
  input  wire logic                      s_axi_rready_i,
  // measurement side, same clock domain
  input  wire logic signed [15:0]        probe1_temp_i,
  input  wire logic signed [15:0]        probe2_temp_i,
  input  wire logic                      probe2_en_i,
  input  wire logic signed [15:0]        setpoint_i,
  input  wire logic [LEVEL_W-1:0]        loop1_demand_i,
  input  wire logic [LEVEL_W-1:0]        loop2_demand_i,
  // front-panel acknowledge button, asynchronous pin
  input  wire logic                      ack_btn_i,
  // outputs
  output logic [LEVEL_W-1:0]             ctrl_out1_o,
  output logic [LEVEL_W-1:0]             ctrl_out2_o,
  output logic                           relay_work_o,
  output logic                           led_out3_o,
  output logic [2:0]                     alarm_flags_o,
  output tal_pkg::tal_msg_t              msg_sel_o
);
  // ****************************************************
  // registers and wires
  // ****************************************************
  tal_pkg::tal_cfg_t    cfg_q;
  tal_pkg::tal_limits_t lim_q;
  logic                 aw_full_q;
  logic                 w_full_q;
  logic [`TAL_ADDR_W-1:0] aw_addr_q;
  logic [31:0]          w_data_q;
  logic [3:0]           w_strb_q;
  logic                 awready_q;
  logic                 wready_q;
  logic                 bvalid_q;
  logic [1:0]           bresp_q;
  logic                 arready_q;
  logic                 rvalid_q;
  logic [31:0]          rdata_q;
  logic [1:0]           rresp_q;
  logic [2:0]           btn_sync_q;
  logic                 sw_ack_q;
  logic [31:0]          blink_cnt_q;
  logic                 blink_q;
  tal_pkg::tal_msg_t    msg_q;
  tal_pkg::tal_msg_t    last_q;
  logic                 relay_q;
  logic                 led_q;
  logic [LEVEL_W-1:0]   out1_q;
  logic [LEVEL_W-1:0]   out2_q;

  logic [2:0]           alarm;
  logic                 any_alarm;
  logic                 ack;
  logic                 btn_rise;
  logic                 aw_hs;
  logic                 w_hs;
  logic                 aw_full_d;
  logic                 w_full_d;
  logic                 do_write;
  logic                 b_hs;
  logic                 ar_hs;
  logic                 r_hs;
  logic                 rvalid_d;
  logic                 bvalid_d;
  logic                 wr_ctrl;
  logic                 wr_modes;
  logic                 wr_abs_hi;
  logic                 wr_abs_lo;
  logic                 wr_dev_hi;
  logic                 wr_dev_lo;
  logic                 wr_ack;
  logic                 wr_hit;
  logic                 rd_hit;
  logic [31:0]          rd_word;
  logic                 blink_tick;
  logic                 p2_use;

  // ****************************************************
  // axi4-lite write path
  // ****************************************************
  assign aw_hs     = s_axi_awvalid_i & awready_q;
  assign w_hs      = s_axi_wvalid_i & wready_q;
  assign b_hs      = bvalid_q & s_axi_bready_i;
  assign do_write  = (aw_full_q | aw_hs) & (w_full_q | w_hs) & ~bvalid_q;
  assign aw_full_d = (aw_full_q | aw_hs) & ~do_write;
  assign w_full_d  = (w_full_q | w_hs) & ~do_write;
  assign bvalid_d  = do_write | (bvalid_q & ~b_hs);

  logic [`TAL_ADDR_W-1:0] wr_addr;
  logic [31:0]            wr_data;
  logic [3:0]             wr_strb;
  assign wr_addr = aw_full_q ? aw_addr_q : s_axi_awaddr_i;
  assign wr_data = w_full_q ? w_data_q : s_axi_wdata_i;
  assign wr_strb = w_full_q ? w_strb_q : s_axi_wstrb_i;

  assign wr_ctrl   = do_write & (wr_addr == `TAL_OFS_CTRL);
  assign wr_modes  = do_write & (wr_addr == `TAL_OFS_MODES);
  assign wr_abs_hi = do_write & (wr_addr == `TAL_OFS_ABS_HI);
  assign wr_abs_lo = do_write & (wr_addr == `TAL_OFS_ABS_LO);
  assign wr_dev_hi = do_write & (wr_addr == `TAL_OFS_DEV_HI);
  assign wr_dev_lo = do_write & (wr_addr == `TAL_OFS_DEV_LO);
  assign wr_ack    = do_write & (wr_addr == `TAL_OFS_ACK);
  assign wr_hit    = wr_ctrl | wr_modes | wr_abs_hi | wr_abs_lo | wr_dev_hi
                   | wr_dev_lo | wr_ack | (wr_addr == `TAL_OFS_STATUS);

  // merge the enabled byte lanes of a 16-bit field
  function automatic logic [15:0] lanes16(input logic [15:0] old_v,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [15:0] res;
    res = old_v;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `TAL_RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      if (aw_hs) begin
        aw_addr_q <= s_axi_awaddr_i;
      end
      if (w_hs) begin
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
      end
      // ready only when the slot is free and no answer is pending
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q  <= ~w_full_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      if (do_write) begin
        bresp_q <= wr_hit ? `TAL_RESP_OKAY : `TAL_RESP_SLVERR;
      end
    end
  end

  // ****************************************************
  // configuration and limit registers
  // ****************************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      // reverse sense, normally closed relay, all alarms off
      {cfg_q.relay_polarity_select, cfg_q.direct_sense} <= `TAL_RST_CTRL;
      cfg_q.deviation_alarm_mode <= tal_pkg::TAL_ALM_OFF;
      cfg_q.abs_low_alarm_mode   <= tal_pkg::TAL_ALM_OFF;
      cfg_q.abs_high_alarm_mode  <= tal_pkg::TAL_ALM_OFF;
      lim_q.abs_high_limit       <= `TAL_RST_LIMIT;
      lim_q.abs_low_limit        <= `TAL_RST_LIMIT;
      lim_q.deviation_high_limit <= `TAL_RST_LIMIT;
      lim_q.deviation_low_limit  <= `TAL_RST_LIMIT;
    end else begin
      if (wr_ctrl & wr_strb[0]) begin
        cfg_q.direct_sense          <= wr_data[`TAL_CTRL_DIRECT];
        cfg_q.relay_polarity_select <= wr_data[`TAL_CTRL_NOPEN];
      end
      if (wr_modes & wr_strb[0]) begin
        // an unused code reads back as given but acts as off
        cfg_q.abs_high_alarm_mode  <= tal_pkg::tal_alm_mode_t'(
          wr_data[`TAL_MODE_HI_LSB +: 2]);
        cfg_q.abs_low_alarm_mode   <= tal_pkg::tal_alm_mode_t'(
          wr_data[`TAL_MODE_LO_LSB +: 2]);
        cfg_q.deviation_alarm_mode <= tal_pkg::tal_alm_mode_t'(
          wr_data[`TAL_MODE_DEV_LSB +: 2]);
      end
      if (wr_abs_hi) begin
        lim_q.abs_high_limit <= lanes16(lim_q.abs_high_limit, wr_data, wr_strb);
      end
      if (wr_abs_lo) begin
        lim_q.abs_low_limit <= lanes16(lim_q.abs_low_limit, wr_data, wr_strb);
      end
      if (wr_dev_hi) begin
        lim_q.deviation_high_limit <=
          lanes16(lim_q.deviation_high_limit, wr_data, wr_strb);
      end
      if (wr_dev_lo) begin
        lim_q.deviation_low_limit <=
          lanes16(lim_q.deviation_low_limit, wr_data, wr_strb);
      end
    end
  end

  // ****************************************************
  // axi4-lite read path
  // ****************************************************
  assign ar_hs    = s_axi_arvalid_i & arready_q;
  assign r_hs     = rvalid_q & s_axi_rready_i;
  assign rvalid_d = ar_hs | (rvalid_q & ~r_hs);
  assign rd_hit   = (s_axi_araddr_i == `TAL_OFS_CTRL) | (s_axi_araddr_i == `TAL_OFS_MODES)
                  | (s_axi_araddr_i == `TAL_OFS_ABS_HI) | (s_axi_araddr_i == `TAL_OFS_ABS_LO)
                  | (s_axi_araddr_i == `TAL_OFS_DEV_HI) | (s_axi_araddr_i == `TAL_OFS_DEV_LO)
                  | (s_axi_araddr_i == `TAL_OFS_STATUS) | (s_axi_araddr_i == `TAL_OFS_ACK);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr_i)
      `TAL_OFS_CTRL: begin
        rd_word[`TAL_CTRL_DIRECT] = cfg_q.direct_sense;
        rd_word[`TAL_CTRL_NOPEN]  = cfg_q.relay_polarity_select;
      end
      `TAL_OFS_MODES: begin
        rd_word[`TAL_MODE_HI_LSB +: 2]  = cfg_q.abs_high_alarm_mode;
        rd_word[`TAL_MODE_LO_LSB +: 2]  = cfg_q.abs_low_alarm_mode;
        rd_word[`TAL_MODE_DEV_LSB +: 2] = cfg_q.deviation_alarm_mode;
      end
      `TAL_OFS_ABS_HI: rd_word[15:0] = lim_q.abs_high_limit;
      `TAL_OFS_ABS_LO: rd_word[15:0] = lim_q.abs_low_limit;
      `TAL_OFS_DEV_HI: rd_word[15:0] = lim_q.deviation_high_limit;
      `TAL_OFS_DEV_LO: rd_word[15:0] = lim_q.deviation_low_limit;
      `TAL_OFS_STATUS: begin
        rd_word[2:0]                  = alarm;
        rd_word[`TAL_ST_ANY]          = any_alarm;
        rd_word[`TAL_ST_MSG_LSB +: 2] = msg_q;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `TAL_RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_hs) begin
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? `TAL_RESP_OKAY : `TAL_RESP_SLVERR;
      end
    end
  end

  // ****************************************************
  // acknowledge: button pin or software write
  // ****************************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      btn_sync_q <= 3'h0;
      sw_ack_q   <= 1'b0;
    end else begin
      btn_sync_q <= {btn_sync_q[1:0], ack_btn_i};
      sw_ack_q   <= wr_ack & wr_strb[0] & wr_data[`TAL_ACK_BIT];
    end
  end

  // edge is taken between the second and third stage only
  assign btn_rise = btn_sync_q[1] & ~btn_sync_q[2];
  assign ack      = btn_rise | sw_ack_q;

  // ****************************************************
  // alarm conditions and channels
  // ****************************************************
  logic cond_hi;
  logic cond_lo;
  logic cond_dev;
  logic signed [16:0] d1;
  logic signed [16:0] d2;

  assign p2_use = probe2_en_i;
  assign d1 = 17'(probe1_temp_i) - 17'(setpoint_i);
  assign d2 = 17'(probe2_temp_i) - 17'(setpoint_i);

  // setpoint plays no part in the absolute limits
  assign cond_hi = (probe1_temp_i > lim_q.abs_high_limit)
                 | (p2_use & (probe2_temp_i > lim_q.abs_high_limit));
  assign cond_lo = (probe1_temp_i < lim_q.abs_low_limit)
                 | (p2_use & (probe2_temp_i < lim_q.abs_low_limit));
  assign cond_dev = (d1 > 17'(lim_q.deviation_high_limit))
                  | (-d1 > 17'(lim_q.deviation_low_limit))
                  | (p2_use & ((d2 > 17'(lim_q.deviation_high_limit))
                  | (-d2 > 17'(lim_q.deviation_low_limit))));

  tal_alarm_chan u_chan_hi (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .mode_i    (cfg_q.abs_high_alarm_mode),
    .cond_i    (cond_hi),
    .ack_i     (ack),
    .active_o  (alarm[0])
  );

  tal_alarm_chan u_chan_lo (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .mode_i    (cfg_q.abs_low_alarm_mode),
    .cond_i    (cond_lo),
    .ack_i     (ack),
    .active_o  (alarm[1])
  );

  tal_alarm_chan u_chan_dev (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .mode_i    (cfg_q.deviation_alarm_mode),
    .cond_i    (cond_dev),
    .ack_i     (ack),
    .active_o  (alarm[2])
  );

  assign any_alarm = |alarm;

  // ****************************************************
  // blink timer and message rotation
  // ****************************************************
  assign blink_tick = (blink_cnt_q == BLINK_CYC - 1);

  tal_pkg::tal_msg_t next_msg;
  always_comb begin
    next_msg = tal_pkg::TAL_MSG_STD;
    // round robin after the last alarm shown
    case (last_q)
      tal_pkg::TAL_MSG_ABS_HI: begin
        if (alarm[1]) next_msg = tal_pkg::TAL_MSG_ABS_LO;
        else if (alarm[2]) next_msg = tal_pkg::TAL_MSG_DEV;
        else if (alarm[0]) next_msg = tal_pkg::TAL_MSG_ABS_HI;
      end
      tal_pkg::TAL_MSG_ABS_LO: begin
        if (alarm[2]) next_msg = tal_pkg::TAL_MSG_DEV;
        else if (alarm[0]) next_msg = tal_pkg::TAL_MSG_ABS_HI;
        else if (alarm[1]) next_msg = tal_pkg::TAL_MSG_ABS_LO;
      end
      default: begin
        if (alarm[0]) next_msg = tal_pkg::TAL_MSG_ABS_HI;
        else if (alarm[1]) next_msg = tal_pkg::TAL_MSG_ABS_LO;
        else if (alarm[2]) next_msg = tal_pkg::TAL_MSG_DEV;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_q     <= 1'b0;
      msg_q       <= tal_pkg::TAL_MSG_STD;
      last_q      <= tal_pkg::TAL_MSG_STD;
    end else begin
      blink_cnt_q <= blink_tick ? 32'h0000_0000 : blink_cnt_q + 32'h0000_0001;
      if (blink_tick) begin
        blink_q <= ~blink_q;
        // each alarm message is followed by the standard display
        if (msg_q == tal_pkg::TAL_MSG_STD) begin
          msg_q <= next_msg;
          if (next_msg != tal_pkg::TAL_MSG_STD) begin
            last_q <= next_msg;
          end
        end else begin
          msg_q <= tal_pkg::TAL_MSG_STD;
        end
      end
    end
  end

  // ****************************************************
  // relay, led and control outputs
  // ****************************************************
  logic relay_d;
  // normally open energises on alarm; normally closed drops out on alarm,
  // so power loss also reads as an alarm
  assign relay_d = cfg_q.relay_polarity_select ? any_alarm
                                               : ~any_alarm;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      relay_q <= 1'b0;
      led_q   <= 1'b0;
      out1_q  <= '0;
      out2_q  <= '0;
    end else begin
      relay_q <= relay_d;
      // led tracks the contact, and blinks over it during an alarm
      led_q   <= any_alarm ? blink_q : relay_d;
      // direct passes the rising demand, reverse mirrors it
      out1_q  <= cfg_q.direct_sense ? loop1_demand_i : ~loop1_demand_i;
      out2_q  <= cfg_q.direct_sense ? loop2_demand_i : ~loop2_demand_i;
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o  = wready_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;
  assign ctrl_out1_o     = out1_q;
  assign ctrl_out2_o     = out2_q;
  assign relay_work_o    = relay_q;
  assign led_out3_o      = led_q;
  assign alarm_flags_o   = alarm;
  assign msg_sel_o       = msg_q;
endmodule
`default_nettype wire

// >>> tb/tal_sva.sv
// port assertions for the temperature alarm block
`default_nettype none
module tal_sva #(
  parameter int unsigned LEVEL_W = 16
) (
  input wire logic               clk_sys_i,
  input wire logic               reset_i,
  input wire logic               s_axi_arvalid_i,
  input wire logic               s_axi_arready_o,
  input wire logic               s_axi_rvalid_o,
  input wire logic               s_axi_bvalid_o,
  input wire logic               s_axi_bready_i,
  input wire logic [LEVEL_W-1:0] loop1_demand_i,
  input wire logic [LEVEL_W-1:0] loop2_demand_i,
  input wire logic [LEVEL_W-1:0] ctrl_out1_o,
  input wire logic [LEVEL_W-1:0] ctrl_out2_o,
  input wire logic               relay_work_o,
  input wire logic               led_out3_o,
  input wire logic [2:0]         alarm_flags_o,
  input wire tal_pkg::tal_msg_t  msg_sel_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // six quiet cycles outlast one blink period of the small bench value
  sequence s_quiet;
    (alarm_flags_o == 3'h0) [*6];
  endsequence
  a_ctrl_sense: assert property (!reset_i |=>
    ctrl_out1_o == $past(loop1_demand_i) || ctrl_out1_o == ~$past(loop1_demand_i))
    else $error("control output neither demand nor its inverse");
  a_loops_same: assert property (!reset_i |=>
    (ctrl_out1_o == $past(loop1_demand_i)) == (ctrl_out2_o == $past(loop2_demand_i)))
    else $error("control outputs disagree on sense");
  a_led_quiet: assert property (s_quiet ##0 $stable(relay_work_o) |->
    led_out3_o == relay_work_o) else $error("led differs from contact");
  a_msg_idle: assert property (s_quiet |->
    msg_sel_o == tal_pkg::TAL_MSG_STD) else $error("alarm message with no alarm");
  a_reset_out: assert property ($fell(reset_i) |=>
    relay_work_o && alarm_flags_o == 3'h0) else $error("bad state after reset");
  a_read_ans: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_ar_refuse: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answer pending");
  a_bresp_drop: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write answer not released");
endmodule
bind tal_top tal_sva #(.LEVEL_W(LEVEL_W)) u_sva (.*);
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the temperature alarm block
`include "tal_params.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'h0, reset_i = 1'h1, ack_btn_i = 1'h0, probe2_en_i = 1'h0;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
  logic [7:0] s_axi_awaddr_i = 8'h0, s_axi_araddr_i = 8'h0;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rd;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic signed [15:0] probe1_temp_i = 16'h0, probe2_temp_i = 16'h0, setpoint_i = 16'h0;
  logic [15:0] loop1_demand_i = 16'h1234, loop2_demand_i = 16'h00f0, ctrl_out1_o, ctrl_out2_o;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic relay_work_o, led_out3_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs;
  logic [2:0] alarm_flags_o;
  tal_pkg::tal_msg_t msg_sel_o;
  int err_total = 0, checks = 0, cyc = 0;
  tal_top #(.BLINK_CYC(4)) uut (.*);
  always #10 clk_sys_i = ~clk_sys_i;
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic b;
    b = 1'h0;
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    while (!b) begin
      @(posedge clk_sys_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
      if (s_axi_bvalid_o) b = 1'h1;
    end
    rs = s_axi_bresp_o;
    s_axi_bready_i <= 1'h0;
  endtask
  task rdr(input logic [7:0] a);
    logic b;
    b = 1'h0;
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    while (!b) begin
      @(posedge clk_sys_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
      if (s_axi_rvalid_o) b = 1'h1;
    end
    rd = s_axi_rdata_o;
    rs = s_axi_rresp_o;
    s_axi_rready_i <= 1'h0;
  endtask
  task end_of_test;
    $display("checks=%0d errors=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task t_reset;
    chk(relay_work_o, 32'h1);
    chk(led_out3_o, 32'h1);
    chk(alarm_flags_o, 32'h0);
    chk(ctrl_out1_o, {~loop1_demand_i});
    rdr(`TAL_OFS_CTRL);
    chk(rd, 32'h0);
    $display("t_reset done");
  endtask
  task t_sense;
    wr(`TAL_OFS_CTRL, 32'h1);
    chk(rs, `TAL_RESP_OKAY);
    wt(2);
    chk(ctrl_out1_o, loop1_demand_i);
    chk(ctrl_out2_o, loop2_demand_i);
    wr(`TAL_OFS_CTRL, 32'h2);
    wt(3);
    chk(relay_work_o, 32'h0);
    chk(led_out3_o, 32'h0);
    chk(ctrl_out2_o, {~loop2_demand_i});
    wr(`TAL_OFS_CTRL, 32'h0);
    wt(3);
    chk(relay_work_o, 32'h1);
    $display("t_sense done");
  endtask
  task t_held;
    logic t, bl, ms;
    bl = 1'h0;
    ms = 1'h0;
    wr(`TAL_OFS_ABS_HI, 32'h64);
    wr(`TAL_OFS_ABS_LO, 32'hff9c);
    wr(`TAL_OFS_MODES, 32'h9);
    probe1_temp_i <= 16'h96;
    wt(3);
    chk(alarm_flags_o, 32'h1);
    chk(relay_work_o, 32'h0);
    t = led_out3_o;
    repeat (12) begin
      @(posedge clk_sys_i);
      if (led_out3_o !== t) bl = 1'h1;
      if (msg_sel_o === tal_pkg::TAL_MSG_ABS_HI) ms = 1'h1;
    end
    chk(bl, 32'h1);
    chk(ms, 32'h1);
    rdr(`TAL_OFS_STATUS);
    chk(rd & 32'hf, 32'h9);
    probe1_temp_i <= 16'h0;
    wt(3);
    chk(alarm_flags_o, 32'h1);
    probe2_en_i <= 1'h1;
    probe2_temp_i <= 16'hc8;
    wr(`TAL_OFS_ACK, 32'h1);
    wt(3);
    chk(alarm_flags_o, 32'h1);
    probe2_temp_i <= 16'h0;
    ack_btn_i <= 1'h1;
    wt(3);
    ack_btn_i <= 1'h0;
    wt(6);
    chk(alarm_flags_o, 32'h0);
    chk(relay_work_o, 32'h1);
    probe2_en_i <= 1'h0;
    $display("t_held done");
  endtask
  task t_self;
    wr(`TAL_OFS_CTRL, 32'h2);
    probe1_temp_i <= 16'hff6a;
    wt(3);
    chk(alarm_flags_o, 32'h2);
    chk(relay_work_o, 32'h1);
    probe1_temp_i <= 16'h0;
    wt(3);
    chk(alarm_flags_o, 32'h0);
    chk(relay_work_o, 32'h0);
    $display("t_self done");
  endtask
  task t_dev;
    logic [15:0] p [4];
    logic [2:0] e [4];
    p = '{16'h78, 16'h3c, 16'h28, 16'hc8};
    e = '{3'h4, 3'h0, 3'h4, 3'h4};
    wr(`TAL_OFS_MODES, 32'h20);
    wr(`TAL_OFS_DEV_HI, 32'ha);
    wr(`TAL_OFS_DEV_LO, 32'h32);
    setpoint_i <= 16'h64;
    for (int i = 0; i < 4; i++) begin
      probe1_temp_i <= p[i];
      wt(3);
      chk(alarm_flags_o, e[i]);
    end
    rdr(`TAL_OFS_DEV_LO);
    chk(rd, 32'h32);
    rdr(8'h20);
    chk(rs, `TAL_RESP_SLVERR);
    wr(8'h20, 32'h1);
    chk(rs, `TAL_RESP_SLVERR);
    $display("t_dev done");
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      end_of_test;
    end
  end
  initial begin
    wt(20);
    reset_i <= 1'h0;
    wt(2);
    t_reset;
    t_sense;
    t_held;
    t_self;
    t_dev;
    end_of_test;
  end
endmodule
`default_nettype wire
